// ### rtl/eeprom_pkg.sv
// Constants, types and state encodings for the two-wire serial EEPROM slave.
// Assumes a single 40 MHz system clock; all bus pins arrive asynchronously.
package eeprom_pkg;

  // ==========================================================================
  // Array organisation
  // ==========================================================================
  localparam int ADDR_W = 16;
  localparam int MEM_DEPTH = 65536;
  localparam int PAGE_W = 7;
  localparam int PAGE_BYTES = 128;
  localparam int BIT_CNT_W = 4;
  localparam logic [BIT_CNT_W-1:0] BITS_PER_BYTE = 4'h8;
  localparam logic [PAGE_W-1:0] PAGE_STEP = 7'h01;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 16'h0001;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;

  // ==========================================================================
  // Slave address byte layout
  // ==========================================================================
  localparam int TYPE_MSB = 7;
  localparam int TYPE_LSB = 4;
  localparam int SEL_MSB = 3;
  localparam int SEL_LSB = 1;
  localparam int RW_BIT = 0;
  // The type code value is arbitrary; a real part would fix it.
  localparam logic [3:0] DEV_TYPE_DEFAULT = 4'h6;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_MHZ = 40;
  localparam int T_WR_US = 5000;
  localparam int WR_CYCLES_DEFAULT = T_WR_US * CLK_MHZ;
  localparam int PROG_CNT_W = 18;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    KIND_DEV,
    KIND_ADDR_HI,
    KIND_ADDR_LO,
    KIND_DATA
  } rx_kind_e;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_MACK
  } bus_state_e;

  typedef struct packed {
    logic scl;
    logic sda;
    logic wp;
    logic [2:0] sel;
  } pins_s;

endpackage

// ### rtl/eeprom_slave.sv
// Two-wire serial EEPROM slave: bus decoder, page buffer, array and write timer.
// Assumes SCL, SDA, write-protect and select pins are asynchronous to clk_sys_i.
//
// Summary of operation
// - Ack data; programming starts at Stop.
// - Bus ignored while programming runs.
// - Page write carries up to 128 bytes.
// - Each data byte increments low seven bits.
// - Page end wraps to page start.
// - Excess bytes overwrite earlier page buffer bytes.
// - Page buffer committed one entry per clock.
// - Poll during programming gets no acknowledge.
// - Poll after programming is acknowledged.
// - Direction bit one selects a read.
// - Counter holds last accessed address plus one; a write at page end leaves it at page start.
// - Current read acks, sends byte at counter.
// - Read after last location returns location zero.
// - Random read returns byte at loaded address.
// - Each master acknowledge yields next sequential byte.
// - Sequential read wraps from top to zero.
// - Match type code and select pins; any direction bit.
// - Acknowledge by pulling SDA low, ninth clock.
// - Write-protect high blocks data bytes and the commit at Stop; a commit already running completes.
`timescale 1ns/1ps

module eeprom_slave #(
  parameter logic [3:0] DEV_TYPE = eeprom_pkg::DEV_TYPE_DEFAULT,
  parameter int WR_CYCLES = eeprom_pkg::WR_CYCLES_DEFAULT
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic wp_i,
  input wire logic addr_select_pin_0_i,
  input wire logic addr_select_pin_1_i,
  input wire logic addr_select_pin_2_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic prog_busy_o
);

  // ==========================================================================
  // Pin synchronisers and bus event detection
  // ==========================================================================
  eeprom_pkg::pins_s pins_meta_reg;
  eeprom_pkg::pins_s pins_sync_reg;
  eeprom_pkg::pins_s pins_last_reg;
  eeprom_pkg::pins_s pins_raw;

  assign pins_raw = '{scl: scl_i, sda: sda_i, wp: wp_i,
                      sel: {addr_select_pin_2_i, addr_select_pin_1_i, addr_select_pin_0_i}};

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pins_meta_reg <= '{scl: 1'b1, sda: 1'b1, wp: 1'b0, sel: 3'h0};
      pins_sync_reg <= '{scl: 1'b1, sda: 1'b1, wp: 1'b0, sel: 3'h0};
      pins_last_reg <= '{scl: 1'b1, sda: 1'b1, wp: 1'b0, sel: 3'h0};
    end else begin
      pins_meta_reg <= pins_raw;
      pins_sync_reg <= pins_meta_reg;
      pins_last_reg <= pins_sync_reg;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_evt;
  logic stop_evt;
  logic wp_on;

  assign scl_rise = pins_sync_reg.scl && !pins_last_reg.scl;
  assign scl_fall = !pins_sync_reg.scl && pins_last_reg.scl;
  assign start_evt = pins_sync_reg.scl && pins_last_reg.scl && pins_last_reg.sda &&
                     !pins_sync_reg.sda;
  assign stop_evt = pins_sync_reg.scl && pins_last_reg.scl && !pins_last_reg.sda &&
                    pins_sync_reg.sda;
  assign wp_on = pins_sync_reg.wp;

  // ==========================================================================
  // Storage
  // ==========================================================================
  logic [7:0] mem [eeprom_pkg::MEM_DEPTH];
  logic [7:0] page_buf [eeprom_pkg::PAGE_BYTES];
  logic [eeprom_pkg::PAGE_BYTES-1:0] page_valid_reg;

  // ==========================================================================
  // Bus protocol engine
  // ==========================================================================
  eeprom_pkg::bus_state_e state_reg;
  eeprom_pkg::rx_kind_e kind_reg;
  logic [eeprom_pkg::BIT_CNT_W-1:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_shift_reg;
  logic [7:0] addr_hi_reg;
  logic [eeprom_pkg::ADDR_W-1:0] addr_reg;
  logic read_reg;
  logic mack_reg;
  logic data_seen_reg;
  logic busy_reg;
  logic sda_oe_reg;
  logic sda_out_reg;
  logic [7:0] rx_byte;
  logic [7:0] rd_byte;
  logic dev_match;
  logic byte_done;
  logic [eeprom_pkg::PAGE_W-1:0] page_idx;

  assign rx_byte = shift_reg;
  assign rd_byte = mem[addr_reg];
  assign page_idx = addr_reg[eeprom_pkg::PAGE_W-1:0];
  assign byte_done = bit_cnt_reg == eeprom_pkg::BITS_PER_BYTE;
  assign dev_match = (rx_byte[eeprom_pkg::TYPE_MSB:eeprom_pkg::TYPE_LSB] == DEV_TYPE) &&
                     (rx_byte[eeprom_pkg::SEL_MSB:eeprom_pkg::SEL_LSB] == pins_sync_reg.sel);

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= eeprom_pkg::ST_IDLE;
      kind_reg <= eeprom_pkg::KIND_DEV;
      bit_cnt_reg <= '0;
      shift_reg <= 8'h00;
      tx_shift_reg <= 8'h00;
      addr_hi_reg <= 8'h00;
      addr_reg <= eeprom_pkg::ADDR_RESET;
      read_reg <= 1'b0;
      mack_reg <= 1'b0;
      data_seen_reg <= 1'b0;
      page_valid_reg <= '0;
      sda_oe_reg <= 1'b0;
    end else if (busy_reg) begin
      // Inputs are disabled: polling addresses see SDA left released.
      state_reg <= eeprom_pkg::ST_IDLE;
      sda_oe_reg <= 1'b0;
      data_seen_reg <= 1'b0;
    end else if (stop_evt) begin
      state_reg <= eeprom_pkg::ST_IDLE;
      sda_oe_reg <= 1'b0;
      data_seen_reg <= 1'b0;
    end else if (start_evt) begin
      // A Start also recovers the engine from any interrupted transfer.
      state_reg <= eeprom_pkg::ST_RX;
      kind_reg <= eeprom_pkg::KIND_DEV;
      bit_cnt_reg <= '0;
      sda_oe_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        eeprom_pkg::ST_IDLE: begin
          sda_oe_reg <= 1'b0;
        end
        eeprom_pkg::ST_RX: begin
          if (scl_rise && !byte_done) begin
            shift_reg <= {shift_reg[6:0], pins_sync_reg.sda};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && byte_done) begin
            bit_cnt_reg <= '0;
            unique case (kind_reg)
              eeprom_pkg::KIND_DEV: begin
                if (dev_match) begin
                  read_reg <= rx_byte[eeprom_pkg::RW_BIT];
                  state_reg <= eeprom_pkg::ST_ACK;
                  sda_oe_reg <= 1'b1;
                  if (!rx_byte[eeprom_pkg::RW_BIT]) begin
                    page_valid_reg <= '0;
                  end
                end else begin
                  state_reg <= eeprom_pkg::ST_IDLE;
                end
              end
              eeprom_pkg::KIND_ADDR_HI: begin
                addr_hi_reg <= rx_byte;
                state_reg <= eeprom_pkg::ST_ACK;
                sda_oe_reg <= 1'b1;
              end
              eeprom_pkg::KIND_ADDR_LO: begin
                // Dummy write of a random read loads the counter here.
                addr_reg <= {addr_hi_reg, rx_byte};
                state_reg <= eeprom_pkg::ST_ACK;
                sda_oe_reg <= 1'b1;
              end
              eeprom_pkg::KIND_DATA: begin
                if (wp_on) begin
                  // A protected array takes no data and returns no acknowledge.
                  state_reg <= eeprom_pkg::ST_IDLE;
                end else begin
                  page_valid_reg[page_idx] <= 1'b1;
                  addr_reg <= {addr_reg[eeprom_pkg::ADDR_W-1:eeprom_pkg::PAGE_W],
                               page_idx + eeprom_pkg::PAGE_STEP};
                  data_seen_reg <= 1'b1;
                  state_reg <= eeprom_pkg::ST_ACK;
                  sda_oe_reg <= 1'b1;
                end
              end
            endcase
          end
        end
        eeprom_pkg::ST_ACK: begin
          if (scl_fall) begin
            sda_oe_reg <= 1'b0;
            if (kind_reg == eeprom_pkg::KIND_DEV && read_reg) begin
              // First bit leaves on the fall that ends the acknowledge.
              sda_oe_reg <= !rd_byte[7];
              tx_shift_reg <= {rd_byte[6:0], 1'b0};
              addr_reg <= addr_reg + eeprom_pkg::ADDR_STEP;
              bit_cnt_reg <= 4'h1;
              state_reg <= eeprom_pkg::ST_TX;
            end else begin
              state_reg <= eeprom_pkg::ST_RX;
              unique case (kind_reg)
                eeprom_pkg::KIND_DEV: kind_reg <= eeprom_pkg::KIND_ADDR_HI;
                eeprom_pkg::KIND_ADDR_HI: kind_reg <= eeprom_pkg::KIND_ADDR_LO;
                eeprom_pkg::KIND_ADDR_LO: kind_reg <= eeprom_pkg::KIND_DATA;
                eeprom_pkg::KIND_DATA: kind_reg <= eeprom_pkg::KIND_DATA;
              endcase
            end
          end
        end
        eeprom_pkg::ST_TX: begin
          if (scl_fall) begin
            if (byte_done) begin
              sda_oe_reg <= 1'b0;
              mack_reg <= 1'b0;
              state_reg <= eeprom_pkg::ST_MACK;
            end else begin
              sda_oe_reg <= !tx_shift_reg[7];
              tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        eeprom_pkg::ST_MACK: begin
          if (scl_rise) begin
            mack_reg <= !pins_sync_reg.sda;
          end else if (scl_fall) begin
            if (mack_reg) begin
              // The counter wraps to zero past the top of the array.
              sda_oe_reg <= !rd_byte[7];
              tx_shift_reg <= {rd_byte[6:0], 1'b0};
              addr_reg <= addr_reg + eeprom_pkg::ADDR_STEP;
              bit_cnt_reg <= 4'h1;
              state_reg <= eeprom_pkg::ST_TX;
            end else begin
              state_reg <= eeprom_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!busy_reg && state_reg == eeprom_pkg::ST_RX && kind_reg == eeprom_pkg::KIND_DATA &&
        scl_fall && byte_done && !wp_on && !stop_evt && !start_evt) begin
      page_buf[page_idx] <= rx_byte;
    end
  end

  // ==========================================================================
  // Internal programming cycle
  // ==========================================================================
  // The commit walks the buffer one entry per clock inside the write time, so
  // the array needs only one write port; the walk is far shorter than T_WR.
  logic [eeprom_pkg::PROG_CNT_W-1:0] prog_cnt_reg;
  logic [eeprom_pkg::ADDR_W-eeprom_pkg::PAGE_W-1:0] prog_page_reg;
  logic [eeprom_pkg::PAGE_W-1:0] prog_idx;
  logic prog_walk;

  assign prog_idx = prog_cnt_reg[eeprom_pkg::PAGE_W-1:0];
  assign prog_walk = prog_cnt_reg < eeprom_pkg::PROG_CNT_W'(eeprom_pkg::PAGE_BYTES);

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_reg <= 1'b0;
      prog_cnt_reg <= '0;
      prog_page_reg <= '0;
    end else if (busy_reg) begin
      if (prog_cnt_reg == eeprom_pkg::PROG_CNT_W'(WR_CYCLES - 1)) begin
        busy_reg <= 1'b0;
      end
      prog_cnt_reg <= prog_cnt_reg + 18'h0_0001;
    end else if (stop_evt && data_seen_reg && !wp_on) begin
      busy_reg <= 1'b1;
      prog_cnt_reg <= '0;
      prog_page_reg <= addr_reg[eeprom_pkg::ADDR_W-1:eeprom_pkg::PAGE_W];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (busy_reg && prog_walk && page_valid_reg[prog_idx]) begin
      mem[{prog_page_reg, prog_idx}] <= page_buf[prog_idx];
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sda_out_reg <= 1'b0;
    end else begin
      sda_out_reg <= 1'b0;
    end
  end

  assign sda_o = sda_out_reg;
  assign sda_oe_o = sda_oe_reg;
  assign prog_busy_o = busy_reg;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);

  a_busy_silent: assert property (busy_reg |-> !sda_oe_o)
    else $error("SDA driven during programming");
  a_poll_nack: assert property (busy_reg && start_evt
      |=> state_reg == eeprom_pkg::ST_IDLE)
    else $error("Engine left idle while programming");
  a_stop_prog: assert property (!busy_reg && stop_evt && data_seen_reg && !wp_on
      |=> busy_reg)
    else $error("Programming did not start at Stop");
  a_no_empty_prog: assert property (!busy_reg && stop_evt && !data_seen_reg |=> !busy_reg)
    else $error("Programming started without data");
  a_wp_block: assert property (!busy_reg && wp_on && stop_evt |=> !busy_reg)
    else $error("Programming started while protected");
  // The wire itself is checked, so a pull-up that beats the drive is caught too.
  a_ack_ninth: assert property (state_reg == eeprom_pkg::ST_ACK && scl_rise
      |-> sda_oe_o && !sda_o && !pins_sync_reg.sda)
    else $error("Acknowledge not low at ninth clock");
  a_page_wrap: assert property (!busy_reg && !stop_evt && !start_evt && !wp_on &&
      state_reg == eeprom_pkg::ST_RX && kind_reg == eeprom_pkg::KIND_DATA && scl_fall && byte_done
      |=> addr_reg[15:7] == $past(addr_reg[15:7]) &&
          addr_reg[6:0] == 7'($past(addr_reg[6:0]) + 7'h01))
    else $error("Page address increment wrong");
  a_read_first: assert property (!busy_reg && !stop_evt && !start_evt &&
      state_reg == eeprom_pkg::ST_ACK && kind_reg == eeprom_pkg::KIND_DEV && read_reg && scl_fall
      |=> sda_oe_o == !$past(rd_byte[7]) &&
          addr_reg == 16'($past(addr_reg) + 16'h0001))
    else $error("Read byte or counter wrong");
  a_seq_next: assert property (!busy_reg && !stop_evt && !start_evt &&
      state_reg == eeprom_pkg::ST_MACK && scl_fall && mack_reg
      |=> state_reg == eeprom_pkg::ST_TX ##1 state_reg == eeprom_pkg::ST_TX)
    else $error("No further byte after acknowledge");
  a_prog_len: assert property ($fell(busy_reg)
      |-> $past(prog_cnt_reg) == eeprom_pkg::PROG_CNT_W'(WR_CYCLES - 1))
    else $error("Programming time wrong");

  c_page_commit: cover property ($fell(busy_reg));
  c_poll_busy: cover property (busy_reg && start_evt);
  c_seq_read: cover property (state_reg == eeprom_pkg::ST_MACK && scl_fall && mack_reg);
  c_read_wrap: cover property (state_reg == eeprom_pkg::ST_TX && addr_reg == 16'h0000);

endmodule

// ### test/i2c_master_model.sv
// Behavioural two-wire bus master standing on the far side of the EEPROM slave.
// Assumes the bench resolves the open-drain data wire and feeds it back on sda_i.
`timescale 1ns/1ps

module i2c_master_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // Extra system clocks per quarter bit; raising it models a slow master.
  int unsigned extra = 0;

  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // ==========================================================================
  // Bit level
  // ==========================================================================
  task automatic q();
    repeat (2 + extra) @(negedge clk_i);
  endtask

  // Data changes only while SCL is low and is sampled in the middle of the high phase.
  task automatic clock_bit(input logic drive_low, output logic seen);
    q();
    sda_low_o = drive_low;
    q();
    scl_o = 1'b1;
    q();
    seen = sda_i;
    q();
    scl_o = 1'b0;
  endtask

  // ==========================================================================
  // Framing
  // ==========================================================================
  // Also serves as a repeated Start; waits for the slave to let go of SDA first.
  task automatic start();
    repeat (2) q();
    sda_low_o = 1'b0;
    q();
    scl_o = 1'b1;
    repeat (2) q();
    sda_low_o = 1'b1;
    repeat (2) q();
    scl_o = 1'b0;
  endtask

  // A single or sequential read ends with a withheld acknowledge, then this.
  task automatic stop();
    q();
    sda_low_o = 1'b1;
    q();
    scl_o = 1'b1;
    repeat (2) q();
    sda_low_o = 1'b0;
    repeat (2) q();
  endtask

  // Bytes go out MSB first and every byte waits for the slave's answer.
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(~b[i], s);
    end
    clock_bit(1'b0, s);
    ack = ~s;
  endtask

  task automatic recv_byte(input logic give_ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b0, s);
      b[i] = s;
    end
    clock_bit(give_ack, s);
    sda_low_o = 1'b0;
  endtask
endmodule

// ### test/serial_eeprom_access_protocol_tb.sv
// Self-checking bench for the two-wire EEPROM slave, driven by the master model.
// Assumes a pull-up on SDA; the write time is shortened so a commit takes 300 clocks.
`timescale 1ns/1ps

module serial_eeprom_access_protocol_tb;
  localparam int WR = 300;
  localparam logic [2:0] SEL = 3'h5;
  logic clk;
  logic resetn;
  logic wp;
  logic scl;
  logic master_low;
  logic sda_out;
  logic sda_oe;
  logic prog_busy;
  logic sda_wire;
  int errors = 0;
  int check_count = 0;

  assign sda_wire = (master_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;

  eeprom_slave #(.DEV_TYPE(eeprom_pkg::DEV_TYPE_DEFAULT), .WR_CYCLES(WR)) i_dut (
    .clk_sys_i(clk), .resetn_i(resetn), .scl_i(scl), .sda_i(sda_wire), .wp_i(wp),
    .addr_select_pin_0_i(SEL[0]), .addr_select_pin_1_i(SEL[1]),
    .addr_select_pin_2_i(SEL[2]), .sda_o(sda_out), .sda_oe_o(sda_oe),
    .prog_busy_o(prog_busy));

  i2c_master_model i_master (.clk_i(clk), .sda_i(sda_wire), .scl_o(scl),
    .sda_low_o(master_low));

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  function automatic logic [7:0] dev(input logic rw);
    return {eeprom_pkg::DEV_TYPE_DEFAULT, SEL, rw};
  endfunction

  task automatic put(input logic [7:0] b, input logic exp_ack, input string what);
    logic a;
    i_master.send_byte(b, a);
    check(8'(a), 8'(exp_ack), what);
  endtask

  task automatic get(input logic give_ack, input logic [7:0] exp, input string what);
    logic [7:0] b;
    i_master.recv_byte(give_ack, b);
    check(b, exp, what);
  endtask

  task automatic set_addr(input logic [15:0] addr);
    i_master.start();
    put(dev(1'b0), 1'b1, "write address");
    put(addr[15:8], 1'b1, "address high");
    put(addr[7:0], 1'b1, "address low");
  endtask

  task automatic wait_busy(input logic lvl, input int limit);
    for (int n = 0; n < limit && prog_busy !== lvl; n++) begin
      @(negedge clk);
    end
  endtask

  task automatic write1(input logic [15:0] addr, input logic [7:0] d);
    set_addr(addr);
    put(d, 1'b1, "write data");
    i_master.stop();
    wait_busy(1'b1, 8);
    check(8'(prog_busy), 8'h01, "write cycle starts");
    wait_busy(1'b0, WR + 50);
    check(8'(prog_busy), 8'h00, "write cycle over");
  endtask

  task automatic read_at(input logic [15:0] addr, input logic [7:0] exp);
    set_addr(addr);
    i_master.start();
    put(dev(1'b1), 1'b1, "read address");
    get(1'b0, exp, "random read");
    i_master.stop();
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_byte_write();
    set_addr(16'h1234);
    put(8'hA5, 1'b1, "data ack");
    i_master.stop();
    wait_busy(1'b1, 8);
    check(8'(prog_busy), 8'h01, "busy after stop");
    i_master.start();
    put(dev(1'b0), 1'b0, "poll while busy");
    i_master.stop();
    wait_busy(1'b0, WR + 50);
    check(8'(prog_busy), 8'h00, "write cycle ends");
    i_master.start();
    put(dev(1'b0), 1'b1, "poll after write");
    put(8'h12, 1'b1, "dummy high");
    put(8'h34, 1'b1, "dummy low");
    i_master.start();
    put(dev(1'b1), 1'b1, "repeated read address");
    get(1'b0, 8'hA5, "byte written");
    i_master.stop();
  endtask

  // 130 bytes from offset 7E: offset o ends up holding byte number o + 2.
  task automatic t_page();
    set_addr(16'h017E);
    for (int k = 0; k < 130; k++) begin
      put(8'(k) ^ 8'h5A, 1'b1, "page data");
    end
    i_master.stop();
    wait_busy(1'b1, 8);
    wait_busy(1'b0, WR + 50);
    check(8'(prog_busy), 8'h00, "page commit done");
    i_master.start();
    put(dev(1'b1), 1'b1, "current read address");
    for (int n = 0; n < 128; n++) begin
      get(n < 127, 8'(n + 2) ^ 8'h5A, "page byte");
    end
    i_master.stop();
  endtask

  task automatic t_wrap();
    write1(16'hFFFF, 8'h3C);
    write1(16'h0000, 8'hC3);
    read_at(16'hFFFF, 8'h3C);
    i_master.start();
    put(dev(1'b1), 1'b1, "current read");
    get(1'b0, 8'hC3, "read after last location");
    i_master.stop();
    set_addr(16'hFFFF);
    i_master.start();
    put(dev(1'b1), 1'b1, "sequential read");
    get(1'b1, 8'h3C, "top byte");
    get(1'b0, 8'hC3, "rolled to zero");
    i_master.stop();
  endtask

  task automatic t_reject();
    for (int b = 1; b < 8; b++) begin
      i_master.start();
      put(dev(1'b0) ^ (8'h01 << b), 1'b0, "foreign address");
      i_master.stop();
    end
  endtask

  task automatic t_protect();
    wp = 1'b1;
    set_addr(16'h1234);
    put(8'h00, 1'b0, "protected data");
    i_master.stop();
    repeat (20) @(negedge clk);
    check(8'(prog_busy), 8'h00, "no cycle when protected");
    wp = 1'b0;
    // Protection raised after an accepted byte must still block the commit.
    set_addr(16'h1234);
    put(8'h00, 1'b1, "data before protect");
    wp = 1'b1;
    repeat (8) @(negedge clk);
    i_master.stop();
    repeat (20) @(negedge clk);
    check(8'(prog_busy), 8'h00, "protect at stop");
    wp = 1'b0;
    read_at(16'h1234, 8'hA5);
  endtask

  // A slow master: the dummy write alone must not start a programming cycle.
  task automatic t_dummy_slow();
    i_master.extra = 3;
    set_addr(16'h1234);
    i_master.stop();
    repeat (20) @(negedge clk);
    check(8'(prog_busy), 8'h00, "stop without data");
    i_master.start();
    put(dev(1'b1), 1'b1, "slow current read");
    get(1'b0, 8'hA5, "loaded address");
    i_master.stop();
    i_master.extra = 0;
  endtask

  // A reset in mid-cycle aborts programming and parks the counter at zero.
  task automatic t_reset_mid();
    set_addr(16'h4000);
    put(8'h77, 1'b1, "data before reset");
    i_master.stop();
    wait_busy(1'b1, 8);
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    check(8'(prog_busy), 8'h00, "busy cleared by reset");
    resetn = 1'b1;
    repeat (8) @(negedge clk);
    i_master.start();
    put(dev(1'b1), 1'b1, "read after reset");
    get(1'b0, 8'hC3, "counter reset to zero");
    i_master.stop();
  endtask

  // ==========================================================================
  // Clock, sequence and watchdog
  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    resetn = 1'b0;
    wp = 1'b0;
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    repeat (8) @(negedge clk);
    t_byte_write();
    t_page();
    t_wrap();
    t_reject();
    t_protect();
    t_dummy_slow();
    t_reset_mid();
    wrap_up();
  end

  // The scenarios need about 30000 clocks; three times that means a hang.
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    wrap_up();
  end
endmodule
